// *** common/cpu_alu_pkg.sv ***
`default_nettype none
package cpu_alu_pkg;
  // Register select codes on the special-function register port
  localparam logic SEL_STATUS = 1'h0;
  localparam logic SEL_CONTROL = 1'h1;
  // Status register field positions
  localparam int B_C = 0;
  localparam int B_Z = 1;
  localparam int B_OVF = 2;
  localparam int B_NEG = 3;
  localparam int B_LOOP = 4;
  localparam int B_PRIO_LO = 5;
  localparam int B_PRIO_HI = 7;
  localparam int B_DCARRY = 8;
  // Control register field positions
  localparam int B_VIS = 2;
  localparam int B_UPPER = 3;
  // Reset values
  localparam logic [15:0] STATUS_RST = 16'h0000;
  localparam logic [15:0] CONTROL_RST = 16'h0000;
  // Divider timing, in core cycles, and shift limit
  localparam int DIV_CYCLES = 19;
  localparam int DIV_ITERS = 16;
  localparam int MAX_SHIFT = 15;
  // Program space
  localparam logic [23:0] USER_ADDR_LIMIT = 24'h7FFFFF;
  localparam int TPAGE_CFG_BIT = 7;

  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_ADD = 4'h1,
    OP_ADDC = 4'h2,
    OP_SUB = 4'h3,
    OP_SUBB = 4'h4,
    OP_AND = 4'h5,
    OP_IOR = 4'h6,
    OP_XOR = 4'h7,
    OP_ASHR = 4'h8,
    OP_LSHR = 4'h9,
    OP_SHL = 4'hA,
    OP_MUL = 4'hB,
    OP_DIV = 4'hC
  } op_t;

  typedef enum logic [2:0] {
    MUL_SS = 3'h0,
    MUL_UU = 3'h1,
    MUL_SU = 3'h2,
    MUL_US = 3'h3,
    MUL_SLIT = 3'h4,
    MUL_ULIT = 3'h5,
    MUL_BB = 3'h6
  } mul_mode_t;

  typedef enum logic [1:0] {
    ASRC_PC = 2'h0,
    ASRC_TABLE = 2'h1,
    ASRC_VIS = 2'h2
  } addr_src_t;
endpackage
`default_nettype wire

// *** verilog/cpu_divider.sv ***
`default_nettype none
module cpu_divider
  import cpu_alu_pkg::*;
#(
  parameter int ITERS = DIV_ITERS
)(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic start_in,
  input wire logic signed_in,
  input wire logic long_in,
  input wire logic [31:0] dividend_in,
  input wire logic [15:0] divisor_in,
  output logic busy_out,
  output logic done_out,
  output logic [15:0] quotient_out,
  output logic [15:0] remainder_out
);
  typedef struct packed {
    logic busy;
    logic done;
    logic [4:0] cnt;
    logic [15:0] rem;
    logic [15:0] quo;
    logic [15:0] dvs;
    logic neg_q;
    logic neg_r;
  } div_state_t;

  div_state_t d_r;
  div_state_t d_nxt;
  logic [16:0] trial;
  logic [31:0] dvd;
  logic [31:0] mag;
  logic [15:0] vmag;
  logic dneg;
  logic vneg;

  if (ITERS != 16 || ITERS + 3 != DIV_CYCLES) begin : g_bad_iters
    $error("cpu_divider: iteration count must be 16");
  end

  always_comb begin
    d_nxt = d_r;
    d_nxt.done = 1'b0;
    trial = {d_r.rem, d_r.quo[15]};
    dvd = long_in ? dividend_in :
          (signed_in ? {{16{dividend_in[15]}}, dividend_in[15:0]} : {16'h0000, dividend_in[15:0]});
    dneg = signed_in & dvd[31];
    vneg = signed_in & divisor_in[15];
    mag = dneg ? 32'h00000000 - dvd : dvd;
    vmag = vneg ? 16'h0000 - divisor_in : divisor_in;
    if (!d_r.busy) begin
      if (start_in) begin
        // Quotient must fit 16 bits; upper half seeds the remainder
        d_nxt.busy = 1'b1;
        d_nxt.cnt = 5'h01;
        d_nxt.rem = mag[31:16];
        d_nxt.quo = mag[15:0];
        d_nxt.dvs = vmag;
        d_nxt.neg_q = dneg ^ vneg;
        d_nxt.neg_r = dneg;
      end
    end else if (d_r.cnt <= 5'(ITERS)) begin
      if (trial >= {1'b0, d_r.dvs}) begin
        d_nxt.rem = 16'(trial - {1'b0, d_r.dvs});
        d_nxt.quo = {d_r.quo[14:0], 1'b1};
      end else begin
        d_nxt.rem = trial[15:0];
        d_nxt.quo = {d_r.quo[14:0], 1'b0};
      end
      d_nxt.cnt = d_r.cnt + 5'h01;
    end else if (d_r.cnt == 5'(ITERS + 1)) begin
      if (d_r.neg_q) begin
        d_nxt.quo = 16'h0000 - d_r.quo;
      end
      if (d_r.neg_r) begin
        d_nxt.rem = 16'h0000 - d_r.rem;
      end
      d_nxt.busy = 1'b0;
      d_nxt.done = 1'b1;
      d_nxt.cnt = 5'h00;
    end else begin
      // Unreachable count falls back to idle
      d_nxt.busy = 1'b0;
      d_nxt.cnt = 5'h00;
    end
  end

  // Clock enable low holds the divide at a cycle boundary
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      d_r <= '0;
    end else if (ce_in) begin
      d_r <= d_nxt;
    end
  end

  assign busy_out = d_r.busy;
  assign done_out = d_r.done;
  assign quotient_out = d_r.quo;
  assign remainder_out = d_r.rem;
endmodule
`default_nettype wire

// *** verilog/cpu_alu_status_control.sv ***
// Overview of operation
// - Digit carry from bit 3 or 7
// - Upper bit joins field, adds eight
// - Field 111 means level seven, masked
// - Priority field read-only when nesting disabled
// - Loop flag follows hardware repeat
// - Negative flag tracks result sign
// - Overflow flag on signed overflow
// - Zero flag sticky for carry ops
// - Carry flag from result MSB
// - Subtraction carries mean no borrow
// - Unimplemented bits read zero
// - Upper bit clear-only, hardware sets
// - Visibility enable bit, resets zero
// - Sixteen-bit two's complement ALU operations
// - Byte or word operand width
// - Seventeen-bit multiplier with seven modes
// - Signed/unsigned long or short divide
// - Quotient to reg zero, remainder one
// - One cycle per divisor bit
// - Single-cycle shifts up to fifteen
// - 24-bit program address from sources
// - User space lower half only
// - Divide takes nineteen cycles
`default_nettype none
module cpu_alu_status_control
  import cpu_alu_pkg::*;
#(
  parameter int SHIFT_MAX = MAX_SHIFT
)(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic op_valid_in,
  input wire op_t op_code_in,
  input wire logic byte_mode_in,
  input wire logic [15:0] opa_in,
  input wire logic [15:0] opb_in,
  input wire logic [3:0] shift_amt_in,
  input wire mul_mode_t mul_mode_in,
  input wire logic div_signed_in,
  input wire logic div_long_in,
  input wire logic [15:0] dividend_hi_in,
  output logic op_ready_out,
  output logic result_valid_out,
  output logic [15:0] result_out,
  output logic [15:0] result_hi_out,
  output logic div_busy_out,
  output logic [15:0] working_reg_zero_out,
  output logic [15:0] working_reg_one_out,
  input wire logic sfr_sel_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [15:0] sfr_wdata_in,
  output logic [15:0] sfr_rdata_out,
  input wire logic repeat_active_in,
  input wire logic nesting_disable_in,
  input wire logic hw_prio_load_in,
  input wire logic [2:0] hw_prio_in,
  input wire logic hw_upper_prio_set_in,
  output logic [3:0] cpu_priority_level_out,
  output logic user_irq_disabled_out,
  output logic program_visibility_enable_out,
  output logic loop_active_flag_out,
  input wire addr_src_t addr_src_in,
  input wire logic [22:0] pc_in,
  input wire logic [7:0] table_page_register_in,
  input wire logic [15:0] table_offset_in,
  input wire logic [7:0] vis_page_in,
  input wire logic [15:0] data_ea_in,
  output logic [23:0] prog_addr_out,
  output logic prog_addr_ok_out
);
  typedef struct packed {
    logic [15:0] result;
    logic [15:0] result_hi;
    logic res_valid;
    logic [15:0] wreg0;
    logic [15:0] wreg1;
    logic dcarry;
    logic [2:0] prio;
    logic loop_active;
    logic neg;
    logic ovf;
    logic zero;
    logic carry;
    logic upper_prio;
    logic prog_vis;
    logic [15:0] rdata;
    logic [23:0] paddr;
    logic paddr_ok;
  } state_t;

  localparam state_t S_RST = '{
    default: '0,
    dcarry: STATUS_RST[B_DCARRY],
    prio: STATUS_RST[B_PRIO_HI:B_PRIO_LO],
    neg: STATUS_RST[B_NEG],
    ovf: STATUS_RST[B_OVF],
    zero: STATUS_RST[B_Z],
    carry: STATUS_RST[B_C],
    upper_prio: CONTROL_RST[B_UPPER],
    prog_vis: CONTROL_RST[B_VIS]
  };

  if (SHIFT_MAX < 1 || SHIFT_MAX > 15) begin : g_bad_shift
    $error("cpu_alu_status_control: shift limit must be 1 to 15");
  end

  state_t s_r;
  state_t s_nxt;
  logic op_take;
  logic is_sub;
  logic use_c;
  logic cin;
  logic [15:0] b_eff;
  logic [16:0] sum17;
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic [3:0] amt;
  logic [16:0] ma;
  logic [16:0] mb;
  logic signed [33:0] prod;
  logic [15:0] res_w;
  logic [15:0] res_m;
  logic upd_arith;
  logic upd_nz;
  logic msb;
  logic is_zero;
  logic [15:0] status_word;
  logic [15:0] control_word;
  logic [23:0] pa;
  logic div_start;
  logic div_done;
  logic [15:0] div_quo;
  logic [15:0] div_rem;

  // Ready also waits out the divide write-back so no result is overwritten
  assign op_take = op_valid_in & op_ready_out;
  assign op_ready_out = ~(div_busy_out | div_done);
  assign div_start = op_take & (op_code_in == OP_DIV);

  assign is_sub = (op_code_in == OP_SUB) | (op_code_in == OP_SUBB);
  assign use_c = (op_code_in == OP_ADDC) | (op_code_in == OP_SUBB);
  assign cin = use_c ? s_r.carry : is_sub;
  assign b_eff = is_sub ? ~opb_in : opb_in;
  assign sum17 = {1'b0, opa_in} + {1'b0, b_eff} + {16'h0000, cin};
  assign sum9 = {1'b0, opa_in[7:0]} + {1'b0, b_eff[7:0]} + {8'h00, cin};
  assign sum5 = {1'b0, opa_in[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};

  assign amt = (shift_amt_in > 4'(SHIFT_MAX)) ? 4'(SHIFT_MAX) : shift_amt_in;

  always_comb begin
    ma = {1'b0, opa_in};
    mb = {1'b0, opb_in};
    case (mul_mode_in)
      MUL_SS: begin
        ma = {opa_in[15], opa_in};
        mb = {opb_in[15], opb_in};
      end
      MUL_SU: ma = {opa_in[15], opa_in};
      MUL_US: mb = {opb_in[15], opb_in};
      MUL_SLIT: begin
        ma = {opa_in[15], opa_in};
        mb = {12'h000, opb_in[4:0]};
      end
      MUL_ULIT: mb = {12'h000, opb_in[4:0]};
      MUL_BB: begin
        ma = {9'h000, opa_in[7:0]};
        mb = {9'h000, opb_in[7:0]};
      end
      default: ma = {1'b0, opa_in};
    endcase
  end
  assign prod = $signed(ma) * $signed(mb);

  assign status_word = {7'h00, s_r.dcarry, s_r.prio, s_r.loop_active,
                        s_r.neg, s_r.ovf, s_r.zero, s_r.carry};
  assign control_word = {12'h000, s_r.upper_prio, s_r.prog_vis, 2'h0};

  always_comb begin
    s_nxt = s_r;
    s_nxt.res_valid = 1'b0;
    s_nxt.loop_active = repeat_active_in;
    res_w = 16'h0000;
    res_m = 16'h0000;
    upd_arith = 1'b0;
    upd_nz = 1'b0;
    msb = 1'b0;
    is_zero = 1'b0;
    pa = 24'h000000;

    if (sfr_rd_in) s_nxt.rdata = (sfr_sel_in == SEL_CONTROL) ? control_word : status_word;
    if (sfr_wr_in && sfr_sel_in == SEL_STATUS) begin
      if (!nesting_disable_in) s_nxt.prio = sfr_wdata_in[B_PRIO_HI:B_PRIO_LO];
      s_nxt.dcarry = sfr_wdata_in[B_DCARRY];
      s_nxt.neg = sfr_wdata_in[B_NEG];
      s_nxt.ovf = sfr_wdata_in[B_OVF];
      s_nxt.zero = sfr_wdata_in[B_Z];
      s_nxt.carry = sfr_wdata_in[B_C];
    end
    if (sfr_wr_in && sfr_sel_in == SEL_CONTROL) begin
      s_nxt.prog_vis = sfr_wdata_in[B_VIS];
      if (!sfr_wdata_in[B_UPPER]) s_nxt.upper_prio = 1'b0;
    end
    // Hardware updates follow software so a set is never lost
    if (hw_prio_load_in) s_nxt.prio = hw_prio_in;
    if (hw_upper_prio_set_in) s_nxt.upper_prio = 1'b1;

    if (op_take) begin
      case (op_code_in)
        OP_ADD, OP_ADDC, OP_SUB, OP_SUBB: begin
          res_w = sum17[15:0];
          upd_arith = 1'b1;
        end
        OP_AND: begin
          res_w = opa_in & opb_in;
          upd_nz = 1'b1;
        end
        OP_IOR: begin
          res_w = opa_in | opb_in;
          upd_nz = 1'b1;
        end
        OP_XOR: begin
          res_w = opa_in ^ opb_in;
          upd_nz = 1'b1;
        end
        OP_ASHR: begin
          res_w = 16'($signed(opa_in) >>> amt);
          upd_nz = 1'b1;
        end
        OP_LSHR: begin
          res_w = opa_in >> amt;
          upd_nz = 1'b1;
        end
        OP_SHL: begin
          res_w = 16'(opa_in << amt);
          upd_nz = 1'b1;
        end
        OP_MUL: begin
          s_nxt.result = prod[15:0];
          s_nxt.result_hi = prod[31:16];
          s_nxt.res_valid = 1'b1;
        end
        default: res_w = 16'h0000;
      endcase
    end

    res_m = (byte_mode_in && !(op_code_in inside {OP_ASHR, OP_LSHR, OP_SHL}))
            ? {opa_in[15:8], res_w[7:0]} : res_w;
    msb = (byte_mode_in && (upd_arith || op_code_in inside {OP_AND, OP_IOR, OP_XOR}))
          ? res_m[7] : res_m[15];
    is_zero = (byte_mode_in && (upd_arith || op_code_in inside {OP_AND, OP_IOR, OP_XOR}))
              ? (res_m[7:0] == 8'h00) : (res_m == 16'h0000);

    // flags outside the op's set hold
    if (upd_arith || upd_nz) begin
      s_nxt.result = res_m;
      s_nxt.res_valid = 1'b1;
      s_nxt.neg = msb;
      s_nxt.zero = use_c && upd_arith ? (s_r.zero & is_zero) : is_zero;
    end
    if (upd_arith) begin
      s_nxt.carry = byte_mode_in ? sum9[8] : sum17[16];
      s_nxt.dcarry = byte_mode_in ? sum5[4] : sum9[8];
      s_nxt.ovf = byte_mode_in ? ((opa_in[7] == b_eff[7]) && (res_m[7] != opa_in[7]))
                               : ((opa_in[15] == b_eff[15]) && (res_m[15] != opa_in[15]));
    end

    if (div_done) begin
      s_nxt.wreg0 = div_quo;
      s_nxt.wreg1 = div_rem;
      s_nxt.result = div_quo;
      s_nxt.res_valid = 1'b1;
      s_nxt.neg = div_quo[15];
      s_nxt.zero = (div_quo == 16'h0000);
    end

    case (addr_src_in)
      ASRC_PC: begin
        pa = {1'b0, pc_in};
        s_nxt.paddr_ok = 1'b1;
      end
      ASRC_TABLE: begin
        pa = {table_page_register_in, table_offset_in};
        s_nxt.paddr_ok = (pa <= USER_ADDR_LIMIT) | table_page_register_in[TPAGE_CFG_BIT];
      end
      ASRC_VIS: begin
        pa = {1'b0, vis_page_in, data_ea_in[14:0]};
        s_nxt.paddr_ok = s_r.prog_vis & data_ea_in[15] & (pa <= USER_ADDR_LIMIT);
      end
      default: begin
        pa = 24'h000000;
        s_nxt.paddr_ok = 1'b0;
      end
    endcase
    s_nxt.paddr = pa;
  end

  cpu_divider #(
    .ITERS(DIV_ITERS)
  ) u_divider (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .start_in(div_start),
    .signed_in(div_signed_in),
    .long_in(div_long_in),
    .dividend_in({dividend_hi_in, opa_in}),
    .divisor_in(opb_in),
    .busy_out(div_busy_out),
    .done_out(div_done),
    .quotient_out(div_quo),
    .remainder_out(div_rem)
  );

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_r <= S_RST;
    end else if (ce_in) begin
      s_r <= s_nxt;
    end
  end

  // level is upper bit then field
  assign cpu_priority_level_out = {s_r.upper_prio, s_r.prio};
  assign user_irq_disabled_out = s_r.upper_prio | (s_r.prio == 3'h7);
  assign program_visibility_enable_out = s_r.prog_vis;
  assign loop_active_flag_out = s_r.loop_active;
  assign result_valid_out = s_r.res_valid;
  assign result_out = s_r.result;
  assign result_hi_out = s_r.result_hi;
  assign working_reg_zero_out = s_r.wreg0;
  assign working_reg_one_out = s_r.wreg1;
  assign sfr_rdata_out = s_r.rdata;
  assign prog_addr_out = s_r.paddr;
  assign prog_addr_ok_out = s_r.paddr_ok;
endmodule
`default_nettype wire

// *** verification/cpu_alu_asserts.sv ***
`default_nettype none
module cpu_alu_asserts
  import cpu_alu_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic op_valid_in,
  input wire op_t op_code_in,
  input wire logic op_ready_out,
  input wire logic result_valid_out,
  input wire logic div_busy_out,
  input wire logic sfr_sel_in,
  input wire logic sfr_wr_in,
  input wire logic [15:0] sfr_wdata_in,
  input wire logic nesting_disable_in,
  input wire logic hw_prio_load_in,
  input wire logic hw_upper_prio_set_in,
  input wire logic [3:0] cpu_priority_level_out,
  input wire logic user_irq_disabled_out,
  input wire logic program_visibility_enable_out,
  input wire logic repeat_active_in,
  input wire logic loop_active_flag_out,
  input wire addr_src_t addr_src_in,
  input wire logic [22:0] pc_in,
  input wire logic [23:0] prog_addr_out,
  input wire logic prog_addr_ok_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  logic take;
  logic ctl_wr;
  assign take = ce_in && op_valid_in && op_ready_out;
  assign ctl_wr = ce_in && sfr_wr_in && sfr_sel_in == SEL_CONTROL;
  AST_IRQ_OFF: assert property (
    user_irq_disabled_out == (cpu_priority_level_out[3] || cpu_priority_level_out[2:0] == 3'h7))
    else $error("irq disable wrong");
  AST_DIV_LEN: assert property (
    take && op_code_in == OP_DIV |-> ##19 (result_valid_out && !div_busy_out))
    else $error("divide length wrong");
  AST_DIV_BUSY: assert property (
    take && op_code_in == OP_DIV |=> (div_busy_out && !op_ready_out)[*8])
    else $error("divide not busy");
  AST_ALU_PULSE: assert property (
    take && !(op_code_in inside {OP_NOP, OP_DIV}) |=> result_valid_out && !div_busy_out)
    else $error("no result pulse");
  AST_VIS_WR: assert property (
    ctl_wr |=> program_visibility_enable_out == $past(sfr_wdata_in[B_VIS]))
    else $error("visibility bit wrong");
  AST_UPPER_HW: assert property (
    ce_in && hw_upper_prio_set_in |=> cpu_priority_level_out[3])
    else $error("upper bit not set");
  AST_UPPER_SW: assert property (
    ctl_wr && !hw_upper_prio_set_in && !cpu_priority_level_out[3] |=> !cpu_priority_level_out[3])
    else $error("software set upper bit");
  AST_PRIO_LOCK: assert property (
    ce_in && nesting_disable_in && !hw_prio_load_in |=> $stable(cpu_priority_level_out[2:0]))
    else $error("locked field changed");
  AST_LOOP: assert property (
    ce_in && $past(rst_n_in) |=> loop_active_flag_out == $past(repeat_active_in))
    else $error("loop flag wrong");
  AST_PC_ADDR: assert property (
    ce_in && $past(rst_n_in) && addr_src_in == ASRC_PC |=> prog_addr_ok_out && prog_addr_out == {1'b0, $past(pc_in)})
    else $error("pc address wrong");
endmodule
bind cpu_alu_status_control cpu_alu_asserts i_chk (.mclk_in, .rst_n_in, .ce_in, .op_valid_in, .op_code_in,
  .op_ready_out, .result_valid_out, .div_busy_out, .sfr_sel_in, .sfr_wr_in, .sfr_wdata_in, .nesting_disable_in,
  .hw_prio_load_in, .hw_upper_prio_set_in, .cpu_priority_level_out, .user_irq_disabled_out,
  .program_visibility_enable_out, .repeat_active_in, .loop_active_flag_out, .addr_src_in, .pc_in, .prog_addr_out,
  .prog_addr_ok_out);
`default_nettype wire

// *** verification/testbench.sv ***
`default_nettype none
module testbench
  import cpu_alu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in = 0, rst_n_in = 0, ce_in = 1, op_valid_in = 0, byte_mode_in = 0, div_signed_in = 0, div_long_in = 0;
  logic sfr_sel_in = 0, sfr_wr_in = 0, sfr_rd_in = 0, repeat_active_in = 0, nesting_disable_in = 0;
  logic hw_prio_load_in = 0, hw_upper_prio_set_in = 0;
  op_t op_code_in = OP_NOP;
  mul_mode_t mul_mode_in = MUL_SS;
  addr_src_t addr_src_in = ASRC_PC;
  logic [15:0] opa_in = 0, opb_in = 0, dividend_hi_in = 0, sfr_wdata_in = 0, table_offset_in = 0, data_ea_in = 0;
  logic [3:0] shift_amt_in = 0;
  logic [2:0] hw_prio_in = 0;
  logic [22:0] pc_in = 0;
  logic [7:0] table_page_register_in = 0, vis_page_in = 0;
  logic op_ready_out, result_valid_out, div_busy_out, user_irq_disabled_out, program_visibility_enable_out;
  logic loop_active_flag_out, prog_addr_ok_out;
  logic [15:0] result_out, result_hi_out, working_reg_zero_out, working_reg_one_out, sfr_rdata_out, q, d, a, b;
  logic [3:0] cpu_priority_level_out;
  logic [23:0] prog_addr_out;
  logic [4:0] fl;
  logic [31:0] r, n, e;
  integer seed = 32'h8107, fail_count = 0, checked = 0;
  op_t c;
  cpu_alu_status_control i_dut (.mclk_in, .rst_n_in, .ce_in, .op_valid_in, .op_code_in, .byte_mode_in, .opa_in,
    .opb_in, .shift_amt_in, .mul_mode_in, .div_signed_in, .div_long_in, .dividend_hi_in, .op_ready_out,
    .result_valid_out, .result_out, .result_hi_out, .div_busy_out, .working_reg_zero_out, .working_reg_one_out,
    .sfr_sel_in, .sfr_wr_in, .sfr_rd_in, .sfr_wdata_in, .sfr_rdata_out, .repeat_active_in, .nesting_disable_in,
    .hw_prio_load_in, .hw_prio_in, .hw_upper_prio_set_in, .cpu_priority_level_out, .user_irq_disabled_out,
    .program_visibility_enable_out, .loop_active_flag_out, .addr_src_in, .pc_in, .table_page_register_in,
    .table_offset_in, .vis_page_in, .data_ea_in, .prog_addr_out, .prog_addr_ok_out);
  initial begin
    forever #5 mclk_in = ~mclk_in;
  end
  task automatic report_and_stop();
    $display("TB: checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic tick();
    @(posedge mclk_in);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // Strobes drop with an idle edge after, so back-to-back calls never re-drive in one step
  task automatic sfr(input logic s, input logic w, input logic [15:0] dat);
    sfr_sel_in = s;
    sfr_wr_in = w;
    sfr_rd_in = !w;
    sfr_wdata_in = dat;
    tick();
    q = sfr_rdata_out;
    sfr_wr_in = 0;
    sfr_rd_in = 0;
    tick();
  endtask
  task automatic op(input op_t oc, input logic [15:0] x, input logic [15:0] y, input logic byt);
    int k;
    op_code_in = oc;
    opa_in = x;
    opb_in = y;
    byte_mode_in = byt;
    op_valid_in = 1;
    tick();
    op_valid_in = 0;
    for (k = 1; result_valid_out !== 1'b1 && k < 40; k++) begin
      if (k == 5) chk(op_ready_out, 0, "ready in divide");
      tick();
    end
    if (k == 40) begin
      fail_count++;
      report_and_stop();
    end
    if (oc == OP_DIV) chk(k, DIV_CYCLES, "divide cycles");
    tick();
  endtask
  // Returns result and {dc, n, ov, z, c}; flags an op leaves alone come from fl
  function automatic logic [20:0] ref_alu(input op_t oc, input logic [15:0] x, input logic [15:0] y,
    input logic byt, input logic [3:0] sh);
    logic [16:0] s, h;
    logic [15:0] yx, m, rr;
    logic ci;
    int w;
    w = byt ? 8 : 16;
    m = byt ? 16'h00FF : 16'hFFFF;
    yx = (oc == OP_SUB || oc == OP_SUBB) ? ~y : y;
    ci = oc == OP_SUB || ((oc == OP_ADDC || oc == OP_SUBB) && fl[0]);
    s = (x & m) + (yx & m) + ci;
    h = (x & (m >> w / 2)) + (yx & (m >> w / 2)) + ci;
    case (oc)
      OP_AND: rr = x & y;
      OP_IOR: rr = x | y;
      OP_XOR: rr = x ^ y;
      OP_ASHR: rr = $signed(x) >>> sh;
      OP_LSHR: rr = x >> sh;
      OP_SHL: rr = x << sh;
      default: rr = byt ? {x[15:8], s[7:0]} : s[15:0];
    endcase
    if (oc inside {OP_ADD, OP_ADDC, OP_SUB, OP_SUBB}) return {rr, h[w / 2], s[w - 1],
      x[w - 1] == yx[w - 1] && s[w - 1] != x[w - 1], (s & m) == 0 && (fl[1] || oc == OP_ADD || oc == OP_SUB), s[w]};
    return {rr, fl[4], rr[15], fl[2], rr == 0, fl[0]};
  endfunction
  function automatic logic [31:0] ref_mul(input mul_mode_t md, input logic [15:0] x, input logic [15:0] y);
    logic [16:0] u, v;
    if (md == MUL_BB) return {16'h0000, 16'(x[7:0]) * 16'(y[7:0])};
    u = {x[15] && md inside {MUL_SS, MUL_SU, MUL_SLIT}, x};
    v = md inside {MUL_SLIT, MUL_ULIT} ? {12'h000, y[4:0]} : {y[15] && md inside {MUL_SS, MUL_US}, y};
    return 32'($signed(u) * $signed(v));
  endfunction
  task automatic dv(input logic sg, input logic lg, input logic [31:0] nn, input logic [15:0] dd);
    logic [31:0] dx, qq, rm;
    div_signed_in = sg;
    div_long_in = lg;
    dividend_hi_in = nn[31:16];
    dx = sg ? {{16{dd[15]}}, dd} : {16'h0000, dd};
    if (sg) begin
      qq = $signed(nn) / $signed(dx);
      rm = $signed(nn) % $signed(dx);
    end else begin
      qq = nn / dx;
      rm = nn % dx;
    end
    op(OP_DIV, nn[15:0], dd, 0);
    chk(working_reg_zero_out, qq[15:0], "quotient");
    chk(working_reg_one_out, rm[15:0], "remainder");
  endtask
  initial begin
    repeat (12) @(posedge mclk_in);
    #1;
    rst_n_in = 1;
    sfr(0, 0, 0);
    chk(q, STATUS_RST, "status reset");
    sfr(1, 0, 0);
    chk(q, CONTROL_RST, "control reset");
    for (int i = 0; i < 8; i++) begin
      sfr(0, 1, {8'hFF, i[2:0], 5'h1F});
      sfr(0, 0, 0);
      chk(q, {7'h00, 1'b1, i[2:0], 5'h0F}, "status rw");
      chk(cpu_priority_level_out, {1'b0, i[2:0]}, "level");
      chk(user_irq_disabled_out, i == 7, "irq off");
    end
    nesting_disable_in = 1;
    sfr(0, 1, 0);
    sfr(0, 0, 0);
    chk(q, 16'h00E0, "field locked");
    nesting_disable_in = 0;
    hw_prio_in = 3'h3;
    hw_prio_load_in = 1;
    tick();
    hw_prio_load_in = 0;
    sfr(1, 1, 16'hFFFF);
    sfr(1, 0, 0);
    chk(q, 16'h0004, "control rw");
    chk(program_visibility_enable_out, 1, "visible");
    hw_upper_prio_set_in = 1;
    tick();
    hw_upper_prio_set_in = 0;
    chk(cpu_priority_level_out, 4'hB, "upper level");
    sfr(1, 1, 0);
    sfr(1, 0, 0);
    chk(q, 0, "upper cleared");
    ce_in = 0;
    sfr(1, 1, 16'h0004);
    ce_in = 1;
    chk(program_visibility_enable_out, 0, "ce freeze");
    repeat_active_in = 1;
    sfr(0, 1, 0);
    sfr(0, 0, 0);
    chk(q, 16'h0010, "loop bit");
    repeat_active_in = 0;
    sfr(0, 1, 0);
    chk(loop_active_flag_out, 0, "loop off");
    $display("TB: register test done");
    fl = 0;
    for (int i = 0; i < 40; i++) begin
      r = $random(seed);
      c = op_t'(i < 4 ? i + 1 : 1 + r[27:16] % 10);
      a = i < 4 ? {15'h0000, i != 1} * (i == 0 ? 16'h7FFF : 16'h0005) : $random(seed);
      b = i < 4 ? (i == 0 ? 16'h0001 : a) : r[15:0];
      shift_amt_in = i == 4 ? 4'hF : r[31:28];
      e = ref_alu(c, a, b, r[30] && c <= OP_SUBB, shift_amt_in);
      op(c, a, b, r[30] && c <= OP_SUBB);
      chk(result_out, e[20:5], "alu result");
      fl = e[4:0];
      sfr(0, 0, 0);
      chk(q, {7'h00, fl[4], 4'h0, fl[3:0]}, "flags");
    end
    $display("TB: alu test done");
    for (int i = 0; i < 14; i++) begin
      mul_mode_in = mul_mode_t'(i / 2);
      a = $random(seed);
      b = $random(seed);
      op(OP_MUL, a, b, 0);
      chk({result_hi_out, result_out}, ref_mul(mul_mode_in, a, b), "product");
    end
    $display("TB: multiply test done");
    dv(0, 1, 32'hFFFEFFFF, 16'hFFFF);
    for (int i = 0; i < 8; i++) begin
      d = $random(seed);
      n = $random(seed);
      if (i[0]) d[14] = !d[15];
      else d[15] = 1;
      if (i[1] && i[0]) n = $signed(n) >>> 3;
      else if (i[1]) n = n >> 1;
      else if (i[0]) n = {{16{n[15]}}, n[15:0]};
      else n[31:16] = 0;
      dv(i[0], i[1], n, d);
    end
    $display("TB: divide test done");
    sfr(1, 1, 16'h0004);
    for (int i = 0; i < 24; i++) begin
      r = $random(seed);
      addr_src_in = addr_src_t'(r[1:0]);
      pc_in = $random(seed);
      table_page_register_in = r[9:2];
      vis_page_in = r[17:10];
      table_offset_in = $random(seed);
      data_ea_in = $random(seed);
      tick();
      case (addr_src_in)
        ASRC_PC: e = {8'h01, 1'b0, pc_in};
        ASRC_TABLE: e = {8'h01, table_page_register_in, table_offset_in};
        ASRC_VIS: e = {7'h00, data_ea_in[15], 1'b0, vis_page_in, data_ea_in[14:0]};
        default: e = 0;
      endcase
      chk({prog_addr_ok_out, prog_addr_out}, e, "prog addr");
    end
    $display("TB: address test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
